/* File: pkg/iqp_pkg.sv */
// Constants and carrier types for the phase, oscillator offset and auto-sync register bank
package iqp_pkg;

   // ****************************************************************
   // Register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [7:0] IQP_IDX_CD_GAIN_A   = 8'h0e; // Staged C gain
   localparam logic [7:0] IQP_IDX_CD_GAIN_B   = 8'h0f; // Staged D gain
   localparam logic [7:0] IQP_IDX_CD_PHASE    = 8'h11; // CD phase correction
   localparam logic [7:0] IQP_IDX_AB_OFFSET   = 8'h12; // AB oscillator phase offset
   localparam logic [7:0] IQP_IDX_CD_OFFSET   = 8'h13; // CD oscillator phase offset
   localparam logic [7:0] IQP_IDX_AB_FREQ_LO  = 8'h14; // AB frequency word, low half
   localparam logic [7:0] IQP_IDX_AB_FREQ_HI  = 8'h15; // AB frequency word, high half
   localparam logic [7:0] IQP_IDX_CD_FREQ_LO  = 8'h16; // CD frequency word, low half
   localparam logic [7:0] IQP_IDX_CD_FREQ_HI  = 8'h17; // CD frequency word, high half
   localparam logic [7:0] IQP_IDX_CORR_SYNC   = 8'h1e; // Correction auto-sync enable
   localparam logic [7:0] IQP_IDX_MIX_SYNC    = 8'h1f; // Mixer auto-sync enable

   // ****************************************************************
   // Field layout
   // ****************************************************************
   localparam int unsigned IQP_ADDR_W     = 12; // APB address width
   localparam int unsigned IQP_GAIN_W     = 11; // Unsigned gain width
   localparam int unsigned IQP_GAIN_FRAC  = 10; // Gain binary point
   localparam int unsigned IQP_PHASE_W    = 12; // Signed phase correction width
   localparam int unsigned IQP_PHASE_FRAC = 12; // Phase correction binary point
   localparam int unsigned IQP_WORD_W     = 16; // Offset and half-word width
   localparam int unsigned IQP_ACC_W      = 32; // Oscillator accumulator width
   localparam int unsigned IQP_SYNC_BIT   = 0;  // Enable bit in sync registers
   localparam int unsigned IQP_FIFO_DEPTH = 16; // Sample buffer depth

   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [10:0] IQP_GAIN_RST   = 11'h400;  // Unity gain
   localparam logic [11:0] IQP_PHASE_RST  = 12'h000;  // No phase correction
   localparam logic [15:0] IQP_WORD_RST   = 16'h0000; // Offsets and frequency halves
   localparam logic        IQP_SYNC_RST   = 1'b0;     // Auto-sync disabled

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic signed [15:0] c; // C-channel sample
      logic signed [15:0] d; // D-channel sample
   } iqp_sample_t;

   typedef struct packed {
      logic signed [15:0] sin_v; // Sine value
      logic signed [15:0] cos_v; // Cosine value
   } iqp_trig_t;

endpackage

/* File: hw/iqp_bank.sv */
// Phase correction, oscillator phase offset bank with auto-sync, sample buffer and datapath
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps

// ********************************************************************
// Sample buffer
// ********************************************************************
module iqp_fifo
#(
   parameter int WIDTH = 32,                       // Word width
   parameter int DEPTH = iqp_pkg::IQP_FIFO_DEPTH   // Word count, power of two
)
(
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire logic             ce_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output      logic             in_ready_out,
   output      logic             out_valid_out,
   output      logic [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage flops
   logic [AW:0]      wr_ptr_reg;       // Write pointer with wrap bit
   logic [AW:0]      rd_ptr_reg;       // Read pointer with wrap bit
   logic             push;             // Word accepted
   logic             pop;              // Word delivered

   // Full when pointers differ by the depth, empty when equal
   assign in_ready_out  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
   assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
   assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
   assign push          = ce_in & in_valid_in & in_ready_out;
   assign pop           = ce_in & out_valid_out & out_ready_in;

   // Pointer update
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

   // Storage write
   always_ff @(posedge clock_in)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
      end
   end
endmodule

// ********************************************************************
// Register bank and datapath
// ********************************************************************
// Operation
// (RULE1) Phase correction is 12-bit signed fraction
// (RULE2) C gains D times active phase correction
// (RULE3) Phase correction resets to zero
// (RULE4) CD phase write syncs gain and phase
// (RULE5) Gain writes alone leave active correction
// (RULE6) Offset added to accumulator upper sixteen bits
// (RULE7) Sixteen-bit sum indexes sine cosine table
// (RULE8) AB offset write syncs AB mixer
// (RULE9) AB frequency writes alone leave mixer
// (RULE10) CD offset write syncs CD mixer
// (RULE11) CD frequency writes alone leave mixer
// (RULE12) Frequency word is signed accumulator step
// (RULE13) Separate staged and active copies kept
module iqp_bank
(
   input  wire logic                  clock_in,        // Converter clock
   input  wire logic                  rst_in,          // Async reset, active high
   input  wire logic                  ce_in,           // Clock enable
   input  wire logic                  psel_in,         // APB select
   input  wire logic                  penable_in,      // APB enable
   input  wire logic                  pwrite_in,       // APB direction
   input  wire logic [11:0]           paddr_in,        // APB byte address
   input  wire logic [31:0]           pwdata_in,       // APB write data
   output      logic [31:0]           prdata_out,      // APB read data
   output      logic                  pready_out,      // APB ready
   output      logic                  pslverr_out,     // APB error
   input  wire logic                  samp_valid_in,   // Sample offered
   input  wire iqp_pkg::iqp_sample_t  samp_in,         // C and D sample
   output      logic                  samp_ready_out,  // Buffer has room
   output      logic                  corr_valid_out,  // Corrected sample held
   output      iqp_pkg::iqp_sample_t  corr_out,        // Corrected sample
   input  wire logic                  corr_ready_in,   // Sink takes sample
   output      logic [15:0]           ab_index_out,    // AB table index
   output      logic [15:0]           cd_index_out,    // CD table index
   output      iqp_pkg::iqp_trig_t    ab_trig_out,     // AB sine and cosine
   output      iqp_pkg::iqp_trig_t    cd_trig_out      // CD sine and cosine
);
   // ****************************************************************
   // Functions
   // ****************************************************************
   // Byte address match for a register index
   function automatic logic addr_hit(input logic [11:0] a, input logic [7:0] idx);
      return a == {2'b00, idx, 2'b00};
   endfunction

   // Clamp to the 16-bit sample range
   function automatic logic signed [15:0] sat16(input logic signed [29:0] v);
      if (v > 30'sh0000_7fff)
         return 16'sh7fff;
      else if (v < 30'sh3fff_8000)
         return 16'sh8000;
      else
         return v[15:0];
   endfunction

   // Quarter-wave sine of the first quadrant, 16 steps
   function automatic logic [15:0] quarter(input logic [3:0] k);
      case (k)
         4'h0: return 16'h0648;
         4'h1: return 16'h12c8;
         4'h2: return 16'h1f1a;
         4'h3: return 16'h2b1f;
         4'h4: return 16'h36ba;
         4'h5: return 16'h41ce;
         4'h6: return 16'h4c3f;
         4'h7: return 16'h55f5;
         4'h8: return 16'h5ed7;
         4'h9: return 16'h66cf;
         4'ha: return 16'h6dc9;
         4'hb: return 16'h73b5;
         4'hc: return 16'h7884;
         4'hd: return 16'h7c29;
         4'he: return 16'h7e9c;
         default: return 16'h7fd8;
      endcase
   endfunction

   // Full-circle sine from a 16-bit phase index
   function automatic logic [15:0] sine(input logic [15:0] idx);
      logic [15:0] mag;
      mag = quarter(idx[14] ? ~idx[13:10] : idx[13:10]);
      return idx[15] ? 16'(-mag) : mag;
   endfunction

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [10:0] stg_gain_c_reg;   // Staged C gain
   logic [10:0] stg_gain_d_reg;   // Staged D gain
   logic [11:0] stg_phase_reg;    // Staged phase correction
   logic [15:0] stg_ab_off_reg;   // Staged AB offset
   logic [15:0] stg_cd_off_reg;   // Staged CD offset
   logic [15:0] stg_ab_lo_reg;    // Staged AB frequency low
   logic [15:0] stg_ab_hi_reg;    // Staged AB frequency high
   logic [15:0] stg_cd_lo_reg;    // Staged CD frequency low
   logic [15:0] stg_cd_hi_reg;    // Staged CD frequency high
   logic        corr_sync_reg;    // Correction auto-sync enable
   logic        mix_sync_reg;     // Mixer auto-sync enable
   logic [10:0] act_gain_c_reg;   // Active C gain
   logic [10:0] act_gain_d_reg;   // Active D gain
   logic [11:0] act_phase_reg;    // Active phase correction
   logic [15:0] act_ab_off_reg;   // Active AB offset
   logic [31:0] act_ab_freq_reg;  // Active AB frequency word
   logic [15:0] act_cd_off_reg;   // Active CD offset
   logic [31:0] act_cd_freq_reg;  // Active CD frequency word
   logic [31:0] ab_acc_reg;       // AB accumulator
   logic [31:0] cd_acc_reg;       // CD accumulator
   logic [31:0] prdata_reg;       // Read data captured in setup
   logic        pslverr_reg;      // Unmapped flag captured in setup

   logic        wr_en;            // Write completes this edge
   logic        setup;            // APB setup cycle
   logic [15:0] wd;               // Write data low half

   assign setup       = ce_in & psel_in & ~penable_in;
   assign wr_en       = ce_in & psel_in & penable_in & pwrite_in;
   assign wd          = pwdata_in[15:0];
   assign pready_out  = ce_in;
   assign prdata_out  = prdata_reg;
   assign pslverr_out = psel_in & penable_in & pslverr_reg;

   // ****************************************************************
   // Staged correction registers
   // ****************************************************************
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         stg_gain_c_reg <= iqp_pkg::IQP_GAIN_RST;
         stg_gain_d_reg <= iqp_pkg::IQP_GAIN_RST;
         stg_phase_reg  <= iqp_pkg::IQP_PHASE_RST; // RULE3
      end
      else if (wr_en)
      begin
         if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_GAIN_A))
         begin
            stg_gain_c_reg <= wd[10:0]; // RULE13
         end
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_GAIN_B))
         begin
            stg_gain_d_reg <= wd[10:0]; // RULE13
         end
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_PHASE))
         begin
            stg_phase_reg <= wd[11:0]; // RULE1
         end
      end
   end

   // ****************************************************************
   // Staged mixer registers
   // ****************************************************************
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         stg_ab_off_reg <= iqp_pkg::IQP_WORD_RST;
         stg_cd_off_reg <= iqp_pkg::IQP_WORD_RST;
         stg_ab_lo_reg  <= iqp_pkg::IQP_WORD_RST;
         stg_ab_hi_reg  <= iqp_pkg::IQP_WORD_RST;
         stg_cd_lo_reg  <= iqp_pkg::IQP_WORD_RST;
         stg_cd_hi_reg  <= iqp_pkg::IQP_WORD_RST;
      end
      else if (wr_en)
      begin
         if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_AB_OFFSET))
            stg_ab_off_reg <= wd;
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_OFFSET))
            stg_cd_off_reg <= wd;
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_AB_FREQ_LO))
            stg_ab_lo_reg <= wd; // RULE13
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_AB_FREQ_HI))
            stg_ab_hi_reg <= wd; // RULE13
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_FREQ_LO))
            stg_cd_lo_reg <= wd; // RULE13
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_FREQ_HI))
            stg_cd_hi_reg <= wd; // RULE13
      end
   end

   // ****************************************************************
   // Auto-sync enables
   // ****************************************************************
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         corr_sync_reg <= iqp_pkg::IQP_SYNC_RST;
         mix_sync_reg  <= iqp_pkg::IQP_SYNC_RST;
      end
      else if (wr_en)
      begin
         if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CORR_SYNC))
            corr_sync_reg <= pwdata_in[iqp_pkg::IQP_SYNC_BIT];
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_MIX_SYNC))
            mix_sync_reg <= pwdata_in[iqp_pkg::IQP_SYNC_BIT];
      end
   end

   // ****************************************************************
   // Active correction, loaded only by the phase write
   // ****************************************************************
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         act_gain_c_reg <= iqp_pkg::IQP_GAIN_RST;
         act_gain_d_reg <= iqp_pkg::IQP_GAIN_RST;
         act_phase_reg  <= iqp_pkg::IQP_PHASE_RST; // RULE3
      end
      else if (wr_en & corr_sync_reg & addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_PHASE))
      begin
         // Gains written earlier join the new phase; gain writes alone do nothing
         act_gain_c_reg <= stg_gain_c_reg; // RULE4 RULE5
         act_gain_d_reg <= stg_gain_d_reg; // RULE4 RULE5
         act_phase_reg  <= wd[11:0];       // RULE4
      end
   end

   // ****************************************************************
   // Active AB mixer, loaded only by the AB offset write
   // ****************************************************************
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         act_ab_off_reg  <= iqp_pkg::IQP_WORD_RST;
         act_ab_freq_reg <= '0;
      end
      else if (wr_en & mix_sync_reg & addr_hit(paddr_in, iqp_pkg::IQP_IDX_AB_OFFSET))
      begin
         act_ab_off_reg  <= wd;                             // RULE8
         act_ab_freq_reg <= {stg_ab_hi_reg, stg_ab_lo_reg}; // RULE8 RULE9
      end
   end

   // ****************************************************************
   // Active CD mixer, loaded only by the CD offset write
   // ****************************************************************
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         act_cd_off_reg  <= iqp_pkg::IQP_WORD_RST;
         act_cd_freq_reg <= '0;
      end
      else if (wr_en & mix_sync_reg & addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_OFFSET))
      begin
         act_cd_off_reg  <= wd;                             // RULE10
         act_cd_freq_reg <= {stg_cd_hi_reg, stg_cd_lo_reg}; // RULE10 RULE11
      end
   end

   // ****************************************************************
   // APB read capture in the setup cycle
   // ****************************************************************
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end
      else if (setup)
      begin
         pslverr_reg <= 1'b0;
         // Reads return staged values, reserved bits zero
         if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_GAIN_A))
            prdata_reg <= {21'h000000, stg_gain_c_reg}; // RULE13
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_GAIN_B))
            prdata_reg <= {21'h000000, stg_gain_d_reg};
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_PHASE))
            prdata_reg <= {20'h00000, stg_phase_reg};
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_AB_OFFSET))
            prdata_reg <= {16'h0000, stg_ab_off_reg};
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_OFFSET))
            prdata_reg <= {16'h0000, stg_cd_off_reg};
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_AB_FREQ_LO))
            prdata_reg <= {16'h0000, stg_ab_lo_reg};
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_AB_FREQ_HI))
            prdata_reg <= {16'h0000, stg_ab_hi_reg};
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_FREQ_LO))
            prdata_reg <= {16'h0000, stg_cd_lo_reg};
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CD_FREQ_HI))
            prdata_reg <= {16'h0000, stg_cd_hi_reg};
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_CORR_SYNC))
            prdata_reg <= {31'h00000000, corr_sync_reg};
         else if (addr_hit(paddr_in, iqp_pkg::IQP_IDX_MIX_SYNC))
            prdata_reg <= {31'h00000000, mix_sync_reg};
         else
         begin
            // Unmapped: zero data and error
            prdata_reg  <= '0;
            pslverr_reg <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Oscillators
   // ****************************************************************
   logic [15:0] ab_index; // AB table index
   logic [15:0] cd_index; // CD table index

   // Offset added to the upper accumulator half, 16-bit wrap
   assign ab_index = ab_acc_reg[31:16] + act_ab_off_reg; // RULE6
   assign cd_index = cd_acc_reg[31:16] + act_cd_off_reg; // RULE6

   // Accumulators step by the signed word, wrapping modulo 2^32
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ab_acc_reg <= '0;
         cd_acc_reg <= '0;
      end
      else if (ce_in)
      begin
         ab_acc_reg <= ab_acc_reg + act_ab_freq_reg; // RULE12
         cd_acc_reg <= cd_acc_reg + act_cd_freq_reg; // RULE12
      end
   end

   // Table lookup, quarter turn ahead for cosine
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ab_index_out <= '0;
         cd_index_out <= '0;
         ab_trig_out  <= '0;
         cd_trig_out  <= '0;
      end
      else if (ce_in)
      begin
         ab_index_out      <= ab_index;
         cd_index_out      <= cd_index;
         ab_trig_out.sin_v <= sine(ab_index);                // RULE7
         ab_trig_out.cos_v <= sine(ab_index + 16'h4000);     // RULE7
         cd_trig_out.sin_v <= sine(cd_index);                // RULE7
         cd_trig_out.cos_v <= sine(cd_index + 16'h4000);     // RULE7
      end
   end

   // ****************************************************************
   // Sample path
   // ****************************************************************
   iqp_pkg::iqp_sample_t      fifo_data;  // Buffer head
   logic                      fifo_valid; // Buffer not empty
   logic                      take;       // Head moves to output stage
   logic signed [27:0]        c_gain;     // C times gain
   logic signed [27:0]        d_gain;     // D times gain
   logic signed [27:0]        d_phase;    // D times phase correction
   logic signed [29:0]        c_sum;      // Corrected C before clamp
   logic signed [29:0]        d_sum;      // Corrected D before clamp

   assign take = fifo_valid & (~corr_valid_out | corr_ready_in);

   iqp_fifo #(.WIDTH($bits(iqp_pkg::iqp_sample_t)), .DEPTH(iqp_pkg::IQP_FIFO_DEPTH)) u_fifo
   (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .ce_in         (ce_in),
      .in_valid_in   (samp_valid_in),
      .in_data_in    (samp_in),
      .in_ready_out  (samp_ready_out),
      .out_valid_out (fifo_valid),
      .out_data_out  (fifo_data),
      .out_ready_in  (take)
   );

   // Gain and phase products
   always_comb
   begin
      c_gain  = fifo_data.c * $signed({1'b0, act_gain_c_reg});
      d_gain  = fifo_data.d * $signed({1'b0, act_gain_d_reg});
      d_phase = fifo_data.d * $signed(act_phase_reg);                    // RULE1 RULE2
      c_sum   = 30'(c_gain >>> iqp_pkg::IQP_GAIN_FRAC)
              + 30'(d_phase >>> iqp_pkg::IQP_PHASE_FRAC);                // RULE2
      d_sum   = 30'(d_gain >>> iqp_pkg::IQP_GAIN_FRAC);
   end

   // Output stage holds until the sink takes it
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         corr_valid_out <= 1'b0;
         corr_out       <= '0;
      end
      else if (ce_in)
      begin
         if (take)
         begin
            corr_valid_out <= 1'b1;
            corr_out.c     <= sat16(c_sum); // RULE2
            corr_out.d     <= sat16(d_sum);
         end
         else if (corr_ready_in)
         begin
            corr_valid_out <= 1'b0;
         end
      end
   end
endmodule

/* File: bench/iqp_bank_checker.sv */
// Port checker for the phase, offset and sync register bank
`timescale 1ns/1ps
// ****
// Checker
// ****
module iqp_bank_checker
(
   input wire logic                 clock_in,
   input wire logic                 rst_in,
   input wire logic                 ce_in,
   input wire logic                 psel_in,
   input wire logic                 penable_in,
   input wire logic [11:0]          paddr_in,
   input wire logic [31:0]          prdata_out,
   input wire logic                 pready_out,
   input wire logic                 pslverr_out,
   input wire logic                 samp_valid_in,
   input wire logic                 samp_ready_out,
   input wire logic                 corr_valid_out,
   input wire iqp_pkg::iqp_sample_t corr_out,
   input wire logic                 corr_ready_in,
   input wire logic [15:0]          ab_index_out,
   input wire logic [15:0]          cd_index_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   property p_ready; pready_out == ce_in; endproperty
   a_ready: assert property (p_ready) else $error("ready differs from enable");
   property p_err; pslverr_out |-> psel_in && penable_in; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   property p_unmap; psel_in && !penable_in && ce_in && paddr_in[1:0] != 2'b00
      |=> pslverr_out && prdata_out == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("misaligned not refused");
   property p_map; psel_in && !penable_in && ce_in && paddr_in == 12'h044 |=> !pslverr_out;
   endproperty
   a_map: assert property (p_map) else $error("mapped refused");
   property p_hold; corr_valid_out && !corr_ready_in && ce_in
      |=> corr_valid_out && $stable(corr_out); endproperty
   a_hold: assert property (p_hold) else $error("output not held");
   property p_pass; samp_valid_in && samp_ready_out && ce_in && !corr_valid_out
      |-> ##2 corr_valid_out;
   endproperty
   a_pass: assert property (p_pass) else $error("sample not passed");
   // Index step may only wobble by a carry while no offset sync is possible
   property p_ab; (ce_in && !rst_in && !(psel_in && paddr_in == 12'h048))[*4] |->
      16'(ab_index_out - 2 * $past(ab_index_out) + $past(ab_index_out, 2))
      inside {16'h0, 16'h1, 16'hffff};
   endproperty
   a_ab: assert property (p_ab) else $error("AB step changed");
   property p_cd; (ce_in && !rst_in && !(psel_in && paddr_in == 12'h04c))[*4] |->
      16'(cd_index_out - 2 * $past(cd_index_out) + $past(cd_index_out, 2))
      inside {16'h0, 16'h1, 16'hffff};
   endproperty
   a_cd: assert property (p_cd) else $error("CD step changed");
endmodule
bind iqp_bank iqp_bank_checker chk_i (.*);

/* File: bench/test_iqp_bank.sv */
// Testbench for the phase, offset and sync register bank
`timescale 1ns/1ps
module test_iqp_bank;
   logic clock_in = 0, rst_in = 1, ce_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic samp_valid_in = 0, corr_ready_in = 0, pready_out, pslverr_out, samp_ready_out, er;
   logic corr_valid_out;
   logic [11:0] paddr_in = 0;
   logic [31:0] pwdata_in = 0, prdata_out, rd, g1, g2, q[$];
   logic [15:0] ab_index_out, cd_index_out, i1, i2;
   iqp_pkg::iqp_sample_t samp_in = 0, corr_out;
   iqp_pkg::iqp_trig_t ab_trig_out, cd_trig_out, t;
   logic [7:0] ix[11] = '{8'h0e, 8'h0f, 8'h11, 8'h12, 8'h13,
      8'h14, 8'h15, 8'h16, 8'h17, 8'h1e, 8'h1f};
   int n_errors = 0, cmp_count = 0, gc = 1024, gd = 1024, ph = 0, j;
   initial forever #20 clock_in = ~clock_in;
   iqp_bank uut (.*);
   // Verdict and end of run
   task end_sim;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin n_errors++; $display("Error at %0t got %h exp %h", $time, g, e); end
   endtask
   // One APB transfer, setup then access until ready
   task apb(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [1:0] m = 0);
      @(posedge clock_in);
      psel_in <= 1; penable_in <= 0; pwrite_in <= w; paddr_in <= {2'b0, i, m}; pwdata_in <= d;
      @(posedge clock_in); penable_in <= 1;
      @(posedge clock_in);
      while (pready_out !== 1'b1) @(posedge clock_in);
      rd = prdata_out; er = pslverr_out; psel_in <= 0; penable_in <= 0;
   endtask
   function logic [15:0] sat(int v);
      return v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : v[15:0];
   endfunction
   function logic [31:0] model(logic [31:0] s);
      int c, d;
      c = $signed(s[31:16]); d = $signed(s[15:0]);
      return {sat(((c * gc) >>> 10) + ((d * ph) >>> 12)), sat((d * gd) >>> 10)};
   endfunction
   // Offer 20 samples with sink stalled, check refusal, then drain and compare
   task run;
      logic [31:0] s;
      for (int k = 0; k < 20; k++) begin
         @(posedge clock_in); s = k == 0 ? 32'h7fff8000 : $urandom;
         samp_valid_in <= 1; samp_in <= s;
         @(negedge clock_in); if (samp_ready_out) q.push_back(model(s));
      end
      chk(samp_ready_out, 0);
      @(posedge clock_in); samp_valid_in <= 0; corr_ready_in <= 1;
      for (int k = 0; k < 40 && q.size() > 0; k++)
      begin
         @(negedge clock_in); if (corr_valid_out) chk(corr_out, q.pop_front());
      end
      chk(q.size(), 0);
      @(posedge clock_in); corr_ready_in <= 0;
   endtask
   initial begin repeat (20000) @(posedge clock_in); n_errors++; end_sim; end
   initial
   begin
      void'($urandom(71));
      repeat (5) @(posedge clock_in); rst_in <= 0;
      foreach (ix[k]) begin apb(0, ix[k], 0); chk(rd, ix[k] < 8'h10 ? 32'h400 : 0); end
      apb(0, 8'h10, 0); chk(er, 1); chk(rd, 0);
      apb(0, 8'h11, 0, 2'd2); chk(er, 1);
      g1 = $urandom_range(2047, 0); g2 = $urandom_range(2047, 0);
      apb(1, 8'h0e, g1); apb(1, 8'h0f, g2); apb(0, 8'h0e, 0); chk(rd, g1);
      run;
      apb(1, 8'h1e, 1); apb(1, 8'h11, 32'h800); apb(0, 8'h11, 0); chk(rd, 32'h800);
      gc = g1; gd = g2; ph = -2048; run;
      for (j = 0; j < 2; j++)
      begin
         apb(1, 8'h1f, 0); apb(1, 8'h12 + j, 32'h1234); repeat (3) @(negedge clock_in);
         chk(j ? cd_index_out : ab_index_out, 0);
         apb(1, 8'h1f, 1); apb(1, 8'h15 + 2 * j, 1); repeat (3) @(negedge clock_in);
         chk(j ? cd_index_out : ab_index_out, 0);
         apb(1, 8'h12 + j, 32'h1234); repeat (2) @(negedge clock_in);
         i1 = j ? cd_index_out : ab_index_out; @(negedge clock_in);
         i2 = j ? cd_index_out : ab_index_out; t = j ? cd_trig_out : ab_trig_out;
         chk(t.cos_v > t.sin_v && t.sin_v > 0, 1);
         chk(i2 - i1, 1);
         chk(i1 - 16'h1234 < 8, 1);
      end
      end_sim;
   end
endmodule
